/* File: hw/hdpb_prepare_end.sv */
// Preparation end: two buffer memories, descriptor posting, read engine.
// Assumes the DMA end fills host-to-card buffers in the order offered.
`timescale 1ns/1ps
`default_nettype none
module hdpb_prepare_end import hdpb_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	hdpb_link_if.dev link_if,
	output logic [31:0] m_axis_tdata_out,
	output logic m_axis_tvalid_out,
	output logic m_axis_tlast_out,
	input wire logic m_axis_tready_in,
	input wire logic [31:0] s_axis_tdata_in,
	input wire logic s_axis_tvalid_in,
	input wire logic s_axis_tlast_in,
	output logic s_axis_tready_out
);
	logic [31:0] h2c_mem [0:`HDPB_MEM_WORDS-1];
	logic [31:0] c2h_mem [0:`HDPB_MEM_WORDS-1];
	logic [12:0] h2c_cnt_q, h2c_cnt_d;
	logic h2c_ev;
	logic [2:0] req_buf [0:7];
	logic [12:0] req_bcnt [0:7];
	logic req_eop [0:7];
	logic [3:0] req_wp_q, req_rp_q;
	hdpb_req_st_t rq_st_q;
	logic rd_valid_q, rd_start_q, rd_eop_q, rd_done_ack_q;
	logic [2:0] rd_buf_q;
	logic [12:0] rd_bcnt_q;
	logic rd_valid_rdy, rd_start_rdy, rd_done_q;
	logic [2:0] vq_buf [0:7];
	logic [12:0] vq_bcnt [0:7];
	logic vq_eop [0:7];
	logic [3:0] vq_wp_q, vq_rp_q, sq_cnt_q;
	logic re_take;
	hdpb_re_st_t re_st_q;
	logic [2:0] re_buf_q;
	logic [9:0] re_ptr_q, re_last_q;
	logic re_eop_q;
	logic [31:0] m_tdata_q;
	logic m_tvalid_q, m_tlast_q;
	logic [7:0] h2c_pend_q, c2h_pend_q, h2c_clr, c2h_clr, c2h_full_q, c2h_full_d;
	hdpb_post_st_t ps_st_q;
	logic [79:0] desc_q;
	logic desc_avail_q, desc_chan_q;
	logic [2:0] desc_buf_q, h2c_sel, c2h_sel, wr_buf_q, wr_buf_d;
	logic [12:0] c2h_bcnt [0:7];
	logic [7:0] c2h_eop_q;
	logic [9:0] wr_word_q;
	logic s_tready_q, c2h_beat, c2h_close;
	logic [31:0] c2h_rd_q;
	logic [12:0] c2h_bytes;
	logic [2:0] c2h_post_q;

	// Host-to-card memory: DMA writes one port, read engine the other
	always_ff @(posedge sys_clk_in) begin
		if (link_if.h2c_wr_valid) begin
			h2c_mem[link_if.h2c_wr_addr[14:2]] <= link_if.h2c_wr_data;
		end
	end

	// Buffer event on a full buffer or a packet end
	assign h2c_cnt_d = h2c_cnt_q + `HDPB_WORD_BYTES;
	assign h2c_ev = link_if.h2c_wr_valid && (link_if.h2c_wr_last || h2c_cnt_d == `HDPB_BUF_BYTES);
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			h2c_cnt_q <= 13'h0000;
		end else if (link_if.h2c_wr_valid) begin
			h2c_cnt_q <= h2c_ev ? 13'h0000 : h2c_cnt_d;
		end
	end

	// Event queue of filled buffers; never more than eight
	always_ff @(posedge sys_clk_in) begin
		if (h2c_ev) begin
			req_buf[req_wp_q[2:0]] <= link_if.h2c_wr_addr[14:12];
			req_bcnt[req_wp_q[2:0]] <= h2c_cnt_d;
			req_eop[req_wp_q[2:0]] <= link_if.h2c_wr_last;
		end
	end

	// Request sequencer: valid handshake, then start handshake
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			req_wp_q <= 4'h0;
			req_rp_q <= 4'h0;
			rq_st_q <= RQ_IDLE;
			rd_valid_q <= 1'b0;
			rd_start_q <= 1'b0;
			rd_buf_q <= 3'h0;
			rd_bcnt_q <= 13'h0000;
			rd_eop_q <= 1'b0;
		end else begin
			req_wp_q <= req_wp_q + {3'h0, h2c_ev};
			unique case (rq_st_q)
				RQ_IDLE: begin
					if (req_wp_q != req_rp_q) begin
						rd_buf_q <= req_buf[req_rp_q[2:0]];
						rd_bcnt_q <= req_bcnt[req_rp_q[2:0]];
						rd_eop_q <= req_eop[req_rp_q[2:0]];
						req_rp_q <= req_rp_q + 4'h1;
						rd_valid_q <= 1'b1;
						rq_st_q <= RQ_VALID;
					end
				end
				RQ_VALID: begin
					if (rd_valid_rdy) begin
						rd_valid_q <= 1'b0;
						rd_start_q <= 1'b1;
						rq_st_q <= RQ_START;
					end
				end
				RQ_START: begin
					if (rd_start_rdy) begin
						rd_start_q <= 1'b0;
						rq_st_q <= RQ_IDLE;
					end
				end
			endcase
		end
	end

	// Read engine queues: valid entries and start tokens kept apart
	assign rd_valid_rdy = (vq_wp_q - vq_rp_q) != 4'h8;
	assign rd_start_rdy = sq_cnt_q != 4'h8;
	assign re_take = re_st_q == RE_IDLE && vq_wp_q != vq_rp_q && sq_cnt_q != 4'h0;
	always_ff @(posedge sys_clk_in) begin
		if (rd_valid_q && rd_valid_rdy) begin
			vq_buf[vq_wp_q[2:0]] <= rd_buf_q;
			vq_bcnt[vq_wp_q[2:0]] <= rd_bcnt_q;
			vq_eop[vq_wp_q[2:0]] <= rd_eop_q;
		end
	end
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			vq_wp_q <= 4'h0;
			vq_rp_q <= 4'h0;
			sq_cnt_q <= 4'h0;
		end else begin
			vq_wp_q <= vq_wp_q + {3'h0, rd_valid_q && rd_valid_rdy};
			vq_rp_q <= vq_rp_q + {3'h0, re_take};
			sq_cnt_q <= sq_cnt_q + {3'h0, rd_start_q && rd_start_rdy} - {3'h0, re_take};
		end
	end

	// Read engine: one beat per fetch, done held until acknowledged
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			re_st_q <= RE_IDLE;
			re_buf_q <= 3'h0;
			re_ptr_q <= 10'h000;
			re_last_q <= 10'h000;
			re_eop_q <= 1'b0;
			m_tdata_q <= 32'h00000000;
			m_tvalid_q <= 1'b0;
			m_tlast_q <= 1'b0;
			rd_done_q <= 1'b0;
		end else begin
			unique case (re_st_q)
				RE_IDLE: begin
					if (re_take) begin
						re_buf_q <= vq_buf[vq_rp_q[2:0]];
						re_last_q <= 10'((vq_bcnt[vq_rp_q[2:0]] - 13'h0001) >> 2);
						re_eop_q <= vq_eop[vq_rp_q[2:0]];
						re_ptr_q <= 10'h000;
						re_st_q <= RE_FETCH;
					end
				end
				RE_FETCH: begin
					m_tdata_q <= h2c_mem[{re_buf_q, re_ptr_q}];
					m_tvalid_q <= 1'b1;
					m_tlast_q <= re_eop_q && re_ptr_q == re_last_q;
					re_st_q <= RE_SEND;
				end
				RE_SEND: begin
					if (m_axis_tready_in) begin
						m_tvalid_q <= 1'b0;
						m_tlast_q <= 1'b0;
						if (re_ptr_q == re_last_q) begin
							rd_done_q <= 1'b1;
							re_st_q <= RE_DONE;
						end else begin
							re_ptr_q <= re_ptr_q + 10'h001;
							re_st_q <= RE_FETCH;
						end
					end
				end
				RE_DONE: begin
					if (rd_done_ack_q) begin
						rd_done_q <= 1'b0;
						re_st_q <= RE_IDLE;
					end
				end
			endcase
		end
	end

	// Preparer acknowledges each completion with a one-cycle pulse
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_done_ack_q <= 1'b0;
		end else begin
			rd_done_ack_q <= rd_done_q && !rd_done_ack_q;
		end
	end

	// Pending posts; a new request wins over a clear in the same cycle
	assign h2c_sel = hdpb_first(h2c_pend_q);
	assign c2h_sel = c2h_post_q; // Oldest closed buffer first keeps the stream in order
	assign h2c_clr = (ps_st_q == PS_HOLD && link_if.desc_done && desc_chan_q == `HDPB_CHAN_H2C) ?
		hdpb_onehot(desc_buf_q) : 8'h00;
	assign c2h_clr = (ps_st_q == PS_HOLD && link_if.desc_done && desc_chan_q == `HDPB_CHAN_C2H) ?
		hdpb_onehot(desc_buf_q) : 8'h00;
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			h2c_pend_q <= `HDPB_H2C_PEND_RST;
			c2h_pend_q <= 8'h00;
			c2h_post_q <= 3'h0;
		end else begin
			h2c_pend_q <= (h2c_pend_q & ~h2c_clr) |
				((rd_done_q && rd_done_ack_q) ? hdpb_onehot(re_buf_q) : 8'h00);
			c2h_pend_q <= (c2h_pend_q & ~c2h_clr) | (c2h_close ? hdpb_onehot(wr_buf_q) : 8'h00);
			c2h_post_q <= c2h_post_q + {2'h0, |c2h_clr};
		end
	end

	// Descriptor poster: one descriptor held until done or error
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ps_st_q <= PS_IDLE;
			desc_q <= 80'h0;
			desc_avail_q <= 1'b0;
			desc_chan_q <= `HDPB_CHAN_H2C;
			desc_buf_q <= 3'h0;
		end else begin
			unique case (ps_st_q)
				PS_IDLE: begin
					if (|h2c_pend_q) begin
						desc_q <= hdpb_make_desc(24'(`HDPB_BUF_BYTES), `HDPB_FLAG_NONE,
							{13'h0000, h2c_sel}, hdpb_buf_addr(`HDPB_H2C_BASE, h2c_sel));
						desc_chan_q <= `HDPB_CHAN_H2C;
						desc_buf_q <= h2c_sel;
						desc_avail_q <= 1'b1;
						ps_st_q <= PS_HOLD;
					end else if (c2h_pend_q[c2h_sel]) begin
						desc_q <= hdpb_make_desc(24'(c2h_bcnt[c2h_sel]),
							c2h_eop_q[c2h_sel] ? `HDPB_FLAG_EOP : `HDPB_FLAG_NONE,
							{13'h1000, c2h_sel}, hdpb_buf_addr(`HDPB_C2H_BASE, c2h_sel));
						desc_chan_q <= `HDPB_CHAN_C2H;
						desc_buf_q <= c2h_sel;
						desc_avail_q <= 1'b1;
						ps_st_q <= PS_HOLD;
					end
				end
				PS_HOLD: begin
					if (link_if.desc_done || link_if.desc_error) begin
						desc_avail_q <= 1'b0;
						ps_st_q <= PS_IDLE;
					end
				end
			endcase
		end
	end

	// Card-to-host fill: stream beats into buffers in turn
	assign c2h_beat = s_axis_tvalid_in && s_tready_q;
	assign c2h_close = c2h_beat && (s_axis_tlast_in || wr_word_q == `HDPB_LAST_WORD);
	assign c2h_bytes = {1'b0, wr_word_q, 2'b00} + `HDPB_WORD_BYTES;
	assign c2h_full_d = (c2h_full_q & ~(link_if.c2h_release ? hdpb_onehot(link_if.c2h_release_buf) :
		8'h00)) | (c2h_close ? hdpb_onehot(wr_buf_q) : 8'h00);
	assign wr_buf_d = c2h_close ? wr_buf_q + 3'h1 : wr_buf_q;
	always_ff @(posedge sys_clk_in) begin
		if (c2h_beat) begin
			c2h_mem[{wr_buf_q, wr_word_q}] <= s_axis_tdata_in;
		end
		if (c2h_close) begin
			c2h_bcnt[wr_buf_q] <= c2h_bytes;
		end
		if (link_if.c2h_rd_en) begin
			c2h_rd_q <= c2h_mem[link_if.c2h_rd_addr[14:2]];
		end
	end
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_buf_q <= 3'h0;
			wr_word_q <= 10'h000;
			c2h_full_q <= 8'h00;
			c2h_eop_q <= 8'h00;
			s_tready_q <= 1'b0;
		end else begin
			wr_buf_q <= wr_buf_d;
			if (c2h_beat) begin
				wr_word_q <= c2h_close ? 10'h000 : wr_word_q + 10'h001;
			end
			if (c2h_close) begin
				c2h_eop_q[wr_buf_q] <= s_axis_tlast_in;
			end
			c2h_full_q <= c2h_full_d;
			s_tready_q <= !c2h_full_d[wr_buf_d];
		end
	end

	assign link_if.desc_avail = desc_avail_q;
	assign link_if.desc_data = desc_q;
	assign link_if.desc_chan = desc_chan_q;
	assign link_if.c2h_rd_data = c2h_rd_q;
	assign m_axis_tdata_out = m_tdata_q;
	assign m_axis_tvalid_out = m_tvalid_q;
	assign m_axis_tlast_out = m_tlast_q;
	assign s_axis_tready_out = s_tready_q;
endmodule
`default_nettype wire

/* File: hw/hdpb_consts.svh */
// Constants of the descriptor preparation buffer: sizes, fields, regions.
// Assumes inclusion by the package and both ends; definitions only.
`ifndef HDPB_CONSTS_SVH
`define HDPB_CONSTS_SVH
`define HDPB_BUF_BYTES 13'h1000
`define HDPB_BUF_COUNT 8
`define HDPB_WORD_BYTES 13'h004
`define HDPB_LAST_WORD 10'h3FF
`define HDPB_MEM_WORDS 8192
`define HDPB_DESC_W 80
`define HDPB_BCNT_LSB 0
`define HDPB_FLAGS_LSB 24
`define HDPB_UID_LSB 32
`define HDPB_ADDR_LSB 48
`define HDPB_FLAG_NONE 8'h00
`define HDPB_FLAG_EOP 8'h01
`define HDPB_CHAN_H2C 1'b0
`define HDPB_CHAN_C2H 1'b1
`define HDPB_H2C_BASE 32'h00000000
`define HDPB_C2H_BASE 32'h00008000
`define HDPB_H2C_PEND_RST 8'hFF
`endif

/* File: hw/hdpb_pkg.sv */
// Types and helper functions shared by both ends of the preparation link.
// Assumes the constants header is on the include path.
`include "hdpb_consts.svh"
package hdpb_pkg;
	typedef enum logic [0:0] {PS_IDLE = 1'b0, PS_HOLD = 1'b1} hdpb_post_st_t;
	typedef enum logic [1:0] {RQ_IDLE = 2'b00, RQ_VALID = 2'b01, RQ_START = 2'b10} hdpb_req_st_t;
	typedef enum logic [1:0] {
		RE_IDLE = 2'b00, RE_FETCH = 2'b01, RE_SEND = 2'b10, RE_DONE = 2'b11
	} hdpb_re_st_t;
	typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_RUN = 2'b01, RD_TAIL = 2'b10} hdpb_rd_st_t;

	// One-hot mask of a buffer index
	function automatic logic [7:0] hdpb_onehot(input logic [2:0] idx);
		hdpb_onehot = 8'h01 << idx;
	endfunction

	// Lowest set bit of a pending mask
	function automatic logic [2:0] hdpb_first(input logic [7:0] bits);
		hdpb_first = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (bits[i]) begin
				hdpb_first = 3'(i);
			end
		end
	endfunction

	// Fixed card address of a buffer inside a region
	function automatic logic [31:0] hdpb_buf_addr(input logic [31:0] base, input logic [2:0] idx);
		hdpb_buf_addr = base + {17'h00000, idx, 12'h000};
	endfunction

	// Descriptor word: count, flags, user id, address
	function automatic logic [`HDPB_DESC_W-1:0] hdpb_make_desc(input logic [23:0] bcnt,
			input logic [7:0] flags, input logic [15:0] uid, input logic [31:0] addr);
		hdpb_make_desc = {addr, uid, flags, bcnt};
	endfunction
endpackage

/* File: hw/hdpb_link_if.sv */
// Link between the preparation end and the DMA submission end.
// Assumes both ends share one clock; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface hdpb_link_if;
	logic desc_avail;
	logic [79:0] desc_data;
	logic desc_chan;
	logic desc_done;
	logic desc_error;
	logic h2c_wr_valid;
	logic [31:0] h2c_wr_addr;
	logic [31:0] h2c_wr_data;
	logic h2c_wr_last;
	logic c2h_rd_en;
	logic [31:0] c2h_rd_addr;
	logic [31:0] c2h_rd_data;
	logic c2h_release;
	logic [2:0] c2h_release_buf;
	modport dev (output desc_avail, desc_data, desc_chan, c2h_rd_data,
		input desc_done, desc_error, h2c_wr_valid, h2c_wr_addr, h2c_wr_data, h2c_wr_last,
		c2h_rd_en, c2h_rd_addr, c2h_release, c2h_release_buf);
	modport dma (input desc_avail, desc_data, desc_chan, c2h_rd_data,
		output desc_done, desc_error, h2c_wr_valid, h2c_wr_addr, h2c_wr_data, h2c_wr_last,
		c2h_rd_en, c2h_rd_addr, c2h_release, c2h_release_buf);
endinterface
`default_nettype wire

/* File: hw/hdpb_dma_end.sv */
// DMA submission end: takes descriptors from the link only, writes host data
// into offered buffers and reads posted card buffers back out.
// Assumes the user side is on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hdpb_dma_end import hdpb_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	hdpb_link_if.dma link_if,
	input wire logic submit_fail_in,
	input wire logic h2c_valid_in,
	input wire logic [31:0] h2c_data_in,
	input wire logic h2c_last_in,
	output logic h2c_ready_out,
	output logic c2h_valid_out,
	output logic [31:0] c2h_data_out,
	output logic c2h_last_out
);
	logic done_q, err_q, take, dpush, spush, dpop, h2c_beat;
	logic [31:0] dq_addr [0:7];
	logic [31:0] sq_addr [0:7];
	logic [12:0] sq_bcnt [0:7];
	logic sq_eop [0:7];
	logic [3:0] dwp_q, drp_q, swp_q, srp_q;
	logic [9:0] hw_word_q;
	logic h2c_ready_q, wr_valid_q, wr_last_q;
	logic [31:0] wr_addr_q, wr_data_q;
	hdpb_rd_st_t rd_st_q;
	logic [31:0] rd_base_q, rd_addr_q;
	logic [9:0] rd_ptr_q, rd_last_q;
	logic rd_eop_q, rd_en_q, rd_l0_q, v1_q, l1_q, rel_q;
	logic c2h_valid_q, c2h_last_q;
	logic [31:0] c2h_data_q;

	// Descriptor intake: done or error, one cycle, once per descriptor
	assign take = link_if.desc_avail && !done_q && !err_q;
	assign dpush = take && !submit_fail_in && link_if.desc_chan == `HDPB_CHAN_H2C;
	assign spush = take && !submit_fail_in && link_if.desc_chan == `HDPB_CHAN_C2H;
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			done_q <= take && !submit_fail_in;
			err_q <= take && submit_fail_in;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (dpush) begin
			dq_addr[dwp_q[2:0]] <= link_if.desc_data[79:48];
		end
		if (spush) begin
			sq_addr[swp_q[2:0]] <= link_if.desc_data[79:48];
			sq_bcnt[swp_q[2:0]] <= link_if.desc_data[12:0];
			sq_eop[swp_q[2:0]] <= link_if.desc_data[24];
		end
	end

	// Host-to-card writer: fills the oldest offered buffer
	assign h2c_beat = h2c_valid_in && h2c_ready_q;
	assign dpop = h2c_beat && (h2c_last_in || hw_word_q == `HDPB_LAST_WORD);
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dwp_q <= 4'h0;
			drp_q <= 4'h0;
			hw_word_q <= 10'h000;
			h2c_ready_q <= 1'b0;
			wr_valid_q <= 1'b0;
			wr_last_q <= 1'b0;
			wr_addr_q <= 32'h00000000;
			wr_data_q <= 32'h00000000;
		end else begin
			dwp_q <= dwp_q + {3'h0, dpush};
			drp_q <= drp_q + {3'h0, dpop};
			h2c_ready_q <= (dwp_q + {3'h0, dpush}) != (drp_q + {3'h0, dpop});
			wr_valid_q <= h2c_beat;
			wr_last_q <= h2c_beat && h2c_last_in;
			if (h2c_beat) begin
				wr_addr_q <= dq_addr[drp_q[2:0]] + {20'h00000, hw_word_q, 2'b00};
				wr_data_q <= h2c_data_in;
				hw_word_q <= dpop ? 10'h000 : hw_word_q + 10'h001;
			end
		end
	end

	// Card-to-host reader: one word per cycle, then release the buffer
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_st_q <= RD_IDLE;
			swp_q <= 4'h0;
			srp_q <= 4'h0;
			rd_base_q <= 32'h00000000;
			rd_addr_q <= 32'h00000000;
			rd_ptr_q <= 10'h000;
			rd_last_q <= 10'h000;
			rd_eop_q <= 1'b0;
			rd_en_q <= 1'b0;
			rd_l0_q <= 1'b0;
			rel_q <= 1'b0;
		end else begin
			swp_q <= swp_q + {3'h0, spush};
			rd_en_q <= 1'b0;
			rd_l0_q <= 1'b0;
			rel_q <= 1'b0;
			unique case (rd_st_q)
				RD_IDLE: begin
					if (swp_q != srp_q) begin
						rd_base_q <= sq_addr[srp_q[2:0]];
						rd_last_q <= 10'((sq_bcnt[srp_q[2:0]] - 13'h0001) >> 2);
						rd_eop_q <= sq_eop[srp_q[2:0]];
						rd_ptr_q <= 10'h000;
						srp_q <= srp_q + 4'h1;
						rd_st_q <= RD_RUN;
					end
				end
				RD_RUN: begin
					rd_en_q <= 1'b1;
					rd_addr_q <= rd_base_q + {20'h00000, rd_ptr_q, 2'b00};
					rd_l0_q <= rd_eop_q && rd_ptr_q == rd_last_q;
					rd_ptr_q <= rd_ptr_q + 10'h001;
					if (rd_ptr_q == rd_last_q) begin
						rd_st_q <= RD_TAIL;
					end
				end
				RD_TAIL: begin
					rel_q <= 1'b1;
					rd_st_q <= RD_IDLE;
				end
				default: begin
					rd_st_q <= RD_IDLE;
				end
			endcase
		end
	end

	// Returned words reach the user two cycles after the read strobe
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			v1_q <= 1'b0;
			l1_q <= 1'b0;
			c2h_valid_q <= 1'b0;
			c2h_last_q <= 1'b0;
			c2h_data_q <= 32'h00000000;
		end else begin
			v1_q <= rd_en_q;
			l1_q <= rd_l0_q;
			c2h_valid_q <= v1_q;
			c2h_last_q <= l1_q;
			c2h_data_q <= v1_q ? link_if.c2h_rd_data : 32'h00000000;
		end
	end

	assign link_if.desc_done = done_q;
	assign link_if.desc_error = err_q;
	assign link_if.h2c_wr_valid = wr_valid_q;
	assign link_if.h2c_wr_addr = wr_addr_q;
	assign link_if.h2c_wr_data = wr_data_q;
	assign link_if.h2c_wr_last = wr_last_q;
	assign link_if.c2h_rd_en = rd_en_q;
	assign link_if.c2h_rd_addr = rd_addr_q;
	assign link_if.c2h_release = rel_q;
	assign link_if.c2h_release_buf = rd_base_q[14:12];
	assign h2c_ready_out = h2c_ready_q;
	assign c2h_valid_out = c2h_valid_q;
	assign c2h_data_out = c2h_data_q;
	assign c2h_last_out = c2h_last_q;
endmodule
`default_nettype wire

/* File: testbench/hdpb_link_sva.sv */
// Checker: descriptor link between the preparation end and the DMA end.
// Assumes one clock domain; inputs are the link interface's own signals.
`timescale 1ns/1ps
`default_nettype none
`include "hdpb_consts.svh"
module hdpb_link_sva (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic desc_avail,
	input wire logic [79:0] desc_data,
	input wire logic desc_chan,
	input wire logic desc_done,
	input wire logic desc_error,
	input wire logic h2c_wr_valid,
	input wire logic [31:0] h2c_wr_addr
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	// Offer and its word stand until the answer comes
	property p_hold;
		desc_avail && !desc_done && !desc_error |=> desc_avail && $stable(desc_data);
	endproperty
	a_hold: assert property (p_hold) else $error("descriptor moved before answer");

	// Exactly one of done or error follows a taken offer
	property p_answer;
		desc_avail && !desc_done && !desc_error |=> desc_done ^ desc_error;
	endproperty
	a_answer: assert property (p_answer) else $error("no single answer to offer");

	// Answer is one cycle and the offer drops for an idle cycle
	property p_gap;
		desc_done || desc_error |=> !desc_avail && !desc_done && !desc_error;
	endproperty
	a_gap: assert property (p_gap) else $error("offer not dropped after answer");

	// Destination offers always announce a whole empty buffer
	property p_h2c_desc;
		desc_avail && desc_chan == `HDPB_CHAN_H2C |->
			desc_data[23:0] == 24'h001000 && desc_data[31:24] == `HDPB_FLAG_NONE;
	endproperty
	a_h2c_desc: assert property (p_h2c_desc) else $error("bad destination offer");

	// Buffer address is fixed by region and index, id carries the channel
	property p_addr;
		desc_avail |-> desc_data[47] == desc_chan && desc_data[79:48] ==
			(desc_chan ? `HDPB_C2H_BASE : `HDPB_H2C_BASE) + {17'h00000, desc_data[34:32], 12'h000};
	endproperty
	a_addr: assert property (p_addr) else $error("offer address off region");

	// Source offers carry whole words, at most one buffer
	property p_c2h_count;
		desc_avail && desc_chan == `HDPB_CHAN_C2H |-> desc_data[23:0] != 24'h000000 &&
			desc_data[23:0] <= 24'h001000 && desc_data[1:0] == 2'h0;
	endproperty
	a_c2h_count: assert property (p_c2h_count) else $error("bad source count");

	// A short source buffer can only have been closed by packet end
	property p_c2h_eop;
		desc_avail && desc_chan == `HDPB_CHAN_C2H && desc_data[23:0] < 24'h001000 |->
			desc_data[24];
	endproperty
	a_c2h_eop: assert property (p_c2h_eop) else $error("short source without end flag");

	// Host writes land word aligned inside the host-to-card region
	property p_wr_region;
		h2c_wr_valid |-> h2c_wr_addr[31:15] == 17'h00000 && h2c_wr_addr[1:0] == 2'h0;
	endproperty
	a_wr_region: assert property (p_wr_region) else $error("write outside region");

	// First offer after reset is destination buffer zero
	property p_first;
		$fell(reset_in) |-> ##[1:2] desc_avail && desc_chan == `HDPB_CHAN_H2C &&
			desc_data[34:32] == 3'h0;
	endproperty
	a_first: assert property (p_first) else $error("first offer wrong");
endmodule
`default_nettype wire

/* File: testbench/hw_descriptor_prepare_buffer_test.sv */
// Testbench: both ends joined by the link, random traffic both ways.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module hw_descriptor_prepare_buffer_test;
	logic clk, rst, m_rdy, s_vld, s_lst, fail, h_vld, h_lst, stress, hold_fail;
	logic [31:0] s_dat, h_dat, m_dat, c_dat;
	logic m_vld, m_lst, s_rdy, h_rdy, c_vld, c_lst;
	logic [32:0] exp_h[$], exp_c[$];
	integer seed = 12;
	int failures, checks_done, posts, bufs, n;
	int lens[11] = '{1, 1024, 1025, 3, 7, 2, 40, 5, 9, 1, 16};

	hdpb_link_if link ();
	hdpb_prepare_end i_hdpb_prepare_end (.sys_clk_in(clk), .reset_in(rst), .link_if(link),
		.m_axis_tdata_out(m_dat), .m_axis_tvalid_out(m_vld), .m_axis_tlast_out(m_lst),
		.m_axis_tready_in(m_rdy), .s_axis_tdata_in(s_dat), .s_axis_tvalid_in(s_vld),
		.s_axis_tlast_in(s_lst), .s_axis_tready_out(s_rdy));
	hdpb_dma_end i_hdpb_dma_end (.sys_clk_in(clk), .reset_in(rst), .link_if(link),
		.submit_fail_in(fail), .h2c_valid_in(h_vld), .h2c_data_in(h_dat), .h2c_last_in(h_lst),
		.h2c_ready_out(h_rdy), .c2h_valid_out(c_vld), .c2h_data_out(c_dat), .c2h_last_out(c_lst));
	hdpb_link_sva i_hdpb_link_sva (.sys_clk_in(clk), .reset_in(rst),
		.desc_avail(link.desc_avail), .desc_data(link.desc_data), .desc_chan(link.desc_chan),
		.desc_done(link.desc_done), .desc_error(link.desc_error),
		.h2c_wr_valid(link.h2c_wr_valid), .h2c_wr_addr(link.h2c_wr_addr));

	// Stream beat compare, end flag above the data word
	task automatic cmp_beat(input string what, input logic [32:0] exp, input logic [32:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Count compare
	task automatic cmp_count(input string what, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up;
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Bounded wait for a ready level at a rising edge
	task automatic wait_for(input string what, ref logic sig);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (sig !== 1'b1 && k < 5000);
		if (k >= 5000) begin
			cmp_count(what, 0, k);
			wrap_up();
		end
	endtask

	// One packet of random words; d picks the card-to-host direction
	task automatic send(input bit d, input int words);
		logic [32:0] w;
		if (d) s_vld <= 1'b1;
		else h_vld <= 1'b1;
		for (int i = 0; i < words; i++) begin
			w = {i == words - 1, 32'($random(seed))};
			if (d) begin
				{s_lst, s_dat} <= w;
				wait_for("c2h ready", s_rdy);
				exp_c.push_back(w);
			end else begin
				{h_lst, h_dat} <= w;
				wait_for("h2c ready", h_rdy);
				exp_h.push_back(w);
			end
		end
		if (d) s_vld <= 1'b0;
		else h_vld <= 1'b0;
		@(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Score beats leaving both ends, count destination posts, stall at random
	always @(posedge clk) begin
		if (!rst && m_vld === 1'b1 && m_rdy === 1'b1) begin
			cmp_beat("h2c beat", exp_h.size() ? exp_h.pop_front() : 33'h0, {m_lst, m_dat});
		end
		if (!rst && c_vld === 1'b1) begin
			cmp_beat("c2h beat", exp_c.size() ? exp_c.pop_front() : 33'h0, {c_lst, c_dat});
		end
		if (link.desc_done === 1'b1 && link.desc_chan === 1'b0) begin
			posts++;
		end
		m_rdy <= ($random(seed) & 3) != 0;
		fail <= hold_fail || (stress && (($random(seed) & 3) == 0));
	end

	// Reset, opening posts, then traffic both ways and drain
	initial begin
		rst = 1'b1;
		{stress, hold_fail, s_vld, s_lst, h_vld, h_lst} = 6'h00;
		s_dat = 32'h00000000;
		h_dat = 32'h00000000;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (100) @(posedge clk);
		cmp_count("h2c posts after reset", 8, posts);
		// Every submission refused: eight card buffers fill and ready must drop
		hold_fail <= 1'b1;
		repeat (8) send(1'b1, 1);
		repeat (3) @(posedge clk);
		cmp_beat("c2h ready when full", 33'h000000000, {32'h00000000, s_rdy});
		hold_fail <= 1'b0;
		wait_for("c2h ready again", s_rdy);
		stress <= 1'b1;
		fork
			foreach (lens[i]) send(1'b0, lens[i]);
			foreach (lens[j]) send(1'b1, lens[j]);
		join
		foreach (lens[k]) bufs += (lens[k] + 1023) / 1024;
		n = 0;
		while ((exp_h.size() != 0 || exp_c.size() != 0) && n < 20000) begin
			@(posedge clk);
			n++;
		end
		repeat (200) @(posedge clk);
		cmp_count("h2c words left", 0, exp_h.size());
		cmp_count("c2h words left", 0, exp_c.size());
		cmp_count("h2c posts total", 8 + bufs, posts);
		wrap_up();
	end
endmodule
`default_nettype wire
